// File: pkg/wdt_pkg.sv
// Shared constants and types for the watchdog timer block.
// Assumes a byte-wide register port with a 14-bit address space.
package wdt_pkg;

    // ==========================================================
    // Register map
    localparam int ADDR_W = 14;                        // Register address width
    localparam logic [13:0] ADDR_FLAGS = 14'h0003;     // core_flags_bank
    localparam logic [13:0] ADDR_CTRL = 14'h0018;      // watchdog_control
    localparam logic [13:0] ADDR_OPTION = 14'h0081;    // timer_option_settings
    localparam logic [13:0] ADDR_FUSE = 14'h2007;      // fuse_settings_word

    // ==========================================================
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h08;           // Period 0100, soft enable off
    localparam logic [7:0] OPTION_RST = 8'hFF;         // Prescaler to watchdog, 1:128
    localparam logic [5:0] FLAGS_OTHER_RST = 6'h00;    // Non-watchdog status bits

    // ==========================================================
    // Field positions
    localparam int CTRL_SOFT_EN_BIT = 0;               // watchdog_soft_enable
    localparam int CTRL_PS_LSB = 1;                    // watchdog_period_select low bit
    localparam int FLAGS_TO_BIT = 4;                   // timeout_flag
    localparam int FLAGS_PD_BIT = 3;                   // powerdown_flag
    localparam int OPT_PSA_BIT = 3;                    // prescaler_assign
    localparam int FUSE_WDT_EN_BIT = 3;                // watchdog_fuse_enable

    // ==========================================================
    // Counter constants
    localparam logic [3:0] PS_MAX_CODE = 4'hB;         // Highest defined period code
    localparam logic [16:0] PS_BASE_DIV = 17'h00020;   // Divide by 32 at code 0000
    localparam logic [7:0] POST_ONE = 8'h01;           // Base of legacy postscaler

    // Register port request
    typedef struct packed {
        logic [13:0] addr;                             // Register address
        logic [7:0] wdata;                             // Write data
        logic wr;                                      // Write strobe
        logic rd;                                      // Read strobe
    } bus_req_t;

endpackage

// File: hw/wdt_core.sv
// Watchdog timer with 16-bit period prescaler and legacy postscaler.
// Assumes the 31 kHz oscillator arrives as a free-running pin level and
// that core events (clear, sleep, wake, start-up hold) are same-clock pulses.
`timescale 1ns/1ps

module wdt_core (
    input wire logic i_sys_clk,                 // System clock, 10 MHz
    input wire logic i_rst_b,                   // Asynchronous reset, active low
    input wire wdt_pkg::bus_req_t i_bus,        // Register port request
    output logic [7:0] o_rdata,                 // Read data, cycle after strobe
    input wire logic i_lfosc,                   // 31 kHz oscillator, async pin
    input wire logic [7:0] i_fuse_word,         // Fuse configuration, async strap
    input wire logic i_clear_watchdog_instr,    // Clear instruction executed
    input wire logic i_osc_fail,                // Oscillator failure detected
    input wire logic i_sleep_enter,             // Sleep instruction executed
    input wire logic i_wake,                    // Wake from a non-watchdog source
    input wire logic i_ost_active,              // Oscillator start-up count running
    output logic o_wdt_reset,                   // Device reset pulse
    output logic o_wdt_wake,                    // Wake-up pulse, execution continues
    output logic o_lfosc_request,               // Keep oscillator running
    output logic o_timer_zero_prescaled,              // Prescaler assigned to timer zero
    output logic [2:0] o_timer_zero_rate              // Timer zero prescale rate
);

    // ==========================================================
    // Decoding helpers

    // Prescaler terminal count for a period code; reserved codes clamp to max
    function automatic logic [15:0] pre_limit(input logic [3:0] ps);
        logic [3:0] code;
        logic [16:0] div;
        code = (ps > wdt_pkg::PS_MAX_CODE) ? wdt_pkg::PS_MAX_CODE : ps;
        div = wdt_pkg::PS_BASE_DIV << code;
        return 16'(div - 17'h00001);
    endfunction

    // Postscaler terminal count; bypassed when timer zero owns it
    function automatic logic [7:0] post_limit(input logic prescaler_assign, input logic [2:0] rate);
        logic [7:0] div;
        div = wdt_pkg::POST_ONE << rate;
        return prescaler_assign ? 8'(div - 8'h01) : 8'h00;
    endfunction

    // ==========================================================
    // Input synchronisers
    logic lf_s1_r, lf_s2_r, lf_s3_r;            // Oscillator sync stages and edge copy
    logic [7:0] fuse_s1_r, fuse_s2_r;           // Fuse word sync stages
    logic lf_tick;                              // One cycle per oscillator rising edge

    // Two flops before any use; third flop only for edge detection
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            lf_s1_r <= 1'b0;
            lf_s2_r <= 1'b0;
            lf_s3_r <= 1'b0;
            fuse_s1_r <= 8'h00;
            fuse_s2_r <= 8'h00;
        end else begin
            lf_s1_r <= i_lfosc;
            lf_s2_r <= lf_s1_r;
            lf_s3_r <= lf_s2_r;
            fuse_s1_r <= i_fuse_word;
            fuse_s2_r <= fuse_s1_r;
        end
    end

    // Counting advances only on oscillator edges, not on the system clock
    assign lf_tick = lf_s2_r & ~lf_s3_r;

    // ==========================================================
    // State
    logic [7:0] ctrl_r, ctrl_nxt;               // watchdog_control
    logic [7:0] option_r, option_nxt;           // timer_option_settings
    logic [5:0] flags_other_r, flags_other_nxt; // Other status bits, plain storage
    logic to_r, to_nxt;                         // timeout_flag
    logic pd_r, pd_nxt;                         // powerdown_flag
    logic asleep_r, asleep_nxt;                 // Device is in sleep
    logic [15:0] pre_r, pre_nxt;                // 16-bit period prescaler
    logic [7:0] post_r, post_nxt;               // Legacy postscaler
    logic [7:0] rdata_r, rdata_nxt;             // Read data register
    logic rst_r, rst_nxt;                       // Reset pulse register
    logic wake_r, wake_nxt;                     // Wake pulse register
    logic lfreq_r, lfreq_nxt;                   // Oscillator request register
    logic timer_zero_pre_r, timer_zero_pre_nxt;             // Timer zero owns the prescaler
    logic fuse_en;                              // Fuse forces watchdog on
    logic wdt_en;                               // Watchdog enabled
    logic clear_evt;                            // Any clearing event this cycle
    logic timeout;                              // Terminal count reached

    assign fuse_en = fuse_s2_r[wdt_pkg::FUSE_WDT_EN_BIT];
    // Fuse wins; soft enable only matters with the fuse clear
    assign wdt_en = fuse_en | ctrl_r[wdt_pkg::CTRL_SOFT_EN_BIT];
    assign timeout = wdt_en & ~i_ost_active & lf_tick
        & (pre_r == pre_limit(ctrl_r[4:1]))
        & (post_r == post_limit(option_r[wdt_pkg::OPT_PSA_BIT], option_r[2:0]));
    assign clear_evt = ~wdt_en | i_clear_watchdog_instr | i_osc_fail
        | (i_wake & asleep_r);

    // ==========================================================
    // Next-state logic: registers, counters, flags, outputs
    always_comb begin
        ctrl_nxt = ctrl_r;
        option_nxt = option_r;
        flags_other_nxt = flags_other_r;
        to_nxt = to_r;
        pd_nxt = pd_r;
        asleep_nxt = asleep_r;
        pre_nxt = pre_r;
        post_nxt = post_r;
        rdata_nxt = 8'h00;
        rst_nxt = 1'b0;
        wake_nxt = 1'b0;
        // Only the enable is signalled; the stable flag stays with the clock unit
        lfreq_nxt = wdt_en;

        // Register writes
        if (i_bus.wr) begin
            unique case (i_bus.addr)
                wdt_pkg::ADDR_CTRL: begin
                    // Unimplemented upper bits stay zero
                    ctrl_nxt = {3'b000, i_bus.wdata[4:0]};
                end
                wdt_pkg::ADDR_OPTION: begin
                    option_nxt = i_bus.wdata;
                end
                wdt_pkg::ADDR_FLAGS: begin
                    // Timeout and powerdown are not software writable
                    flags_other_nxt = {i_bus.wdata[7:5], i_bus.wdata[2:0]};
                end
                default: begin
                    // Fuse word and unmapped addresses ignore writes
                end
            endcase
        end

        // Register reads, answered in the following cycle
        if (i_bus.rd) begin
            unique case (i_bus.addr)
                wdt_pkg::ADDR_CTRL: rdata_nxt = ctrl_r;
                wdt_pkg::ADDR_OPTION: rdata_nxt = option_r;
                wdt_pkg::ADDR_FLAGS: rdata_nxt = {flags_other_r[5:3], to_r, pd_r, flags_other_r[2:0]};
                wdt_pkg::ADDR_FUSE: rdata_nxt = fuse_s2_r;
                default: rdata_nxt = 8'h00;
            endcase
        end

        // Counter path
        if (i_ost_active) begin
            // Ripple counter lent to start-up timer
            pre_nxt = 16'h0000;
            post_nxt = 8'h00;
        end else if (clear_evt) begin
            pre_nxt = 16'h0000;
            post_nxt = 8'h00;
        end else if (timeout) begin
            pre_nxt = 16'h0000;
            post_nxt = 8'h00;
            to_nxt = 1'b0;
            if (asleep_r) begin
                wake_nxt = 1'b1;
                asleep_nxt = 1'b0;
            end else begin
                rst_nxt = 1'b1;
            end
        end else if (lf_tick) begin
            // Prescaler feeds postscaler on its terminal count
            if (pre_r == pre_limit(ctrl_r[4:1])) begin
                pre_nxt = 16'h0000;
                post_nxt = 8'(post_r + 8'h01);
            end else begin
                pre_nxt = 16'(pre_r + 16'h0001);
            end
        end

        // Wake leaves sleep even while the start-up count holds the counter
        if (i_wake & asleep_r) begin
            asleep_nxt = 1'b0;
        end

        // Clear instruction restores both flags
        if (i_clear_watchdog_instr) begin
            to_nxt = 1'b1;
            pd_nxt = 1'b1;
        end

        // Sleep entry; the watchdog keeps counting from zero
        if (i_sleep_enter & wdt_en & ~asleep_r) begin
            asleep_nxt = 1'b1;
            pd_nxt = 1'b0;
            to_nxt = 1'b1;
            pre_nxt = 16'h0000;
            post_nxt = 8'h00;
        end
        // Registered so the output comes straight from a flop
        timer_zero_pre_nxt = ~option_nxt[wdt_pkg::OPT_PSA_BIT];
    end

    // Register stage; control resets to its documented pattern on every reset
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_r <= wdt_pkg::CTRL_RST;
            option_r <= wdt_pkg::OPTION_RST;
            flags_other_r <= wdt_pkg::FLAGS_OTHER_RST;
            to_r <= 1'b1;
            pd_r <= 1'b1;
            asleep_r <= 1'b0;
            pre_r <= 16'h0000;
            post_r <= 8'h00;
            rdata_r <= 8'h00;
            rst_r <= 1'b0;
            wake_r <= 1'b0;
            lfreq_r <= 1'b0;
            timer_zero_pre_r <= ~wdt_pkg::OPTION_RST[wdt_pkg::OPT_PSA_BIT];
        end else begin
            ctrl_r <= ctrl_nxt;
            option_r <= option_nxt;
            flags_other_r <= flags_other_nxt;
            to_r <= to_nxt;
            pd_r <= pd_nxt;
            asleep_r <= asleep_nxt;
            pre_r <= pre_nxt;
            post_r <= post_nxt;
            rdata_r <= rdata_nxt;
            rst_r <= rst_nxt;
            wake_r <= wake_nxt;
            lfreq_r <= lfreq_nxt;
            timer_zero_pre_r <= timer_zero_pre_nxt;
        end
    end

    // ==========================================================
    // Outputs, all straight from flops
    assign o_rdata = rdata_r;
    assign o_wdt_reset = rst_r;
    assign o_wdt_wake = wake_r;
    assign o_lfosc_request = lfreq_r;
    assign o_timer_zero_prescaled = timer_zero_pre_r;
    assign o_timer_zero_rate = option_r[2:0];

    // ==========================================================
    // Assertions
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);

    a_ctrl_upper_zero: assert property (ctrl_r[7:5] == 3'b000)
        else $error("control upper bits not zero");
    a_rdata_ctrl: assert property (i_bus.rd && i_bus.addr == wdt_pkg::ADDR_CTRL
        |=> o_rdata == {3'b000, $past(ctrl_r[4:0])})
        else $error("control read data wrong");
    a_ost_hold: assert property (i_ost_active [*2] |=> pre_r == 16'h0000 && post_r == 8'h00)
        else $error("counter not held during start-up");
    a_disabled_clear: assert property (!fuse_en && !ctrl_r[0] |=> pre_r == 16'h0000)
        else $error("disabled watchdog counting");
    a_fuse_runs: assert property (fuse_en && !ctrl_r[0] && lf_tick && !i_ost_active && !clear_evt
        && !timeout && !i_sleep_enter && pre_r != pre_limit(ctrl_r[4:1])
        |=> pre_r == 16'($past(pre_r) + 16'h0001))
        else $error("fuse enabled watchdog not counting");
    a_timeout_reset: assert property (timeout && !asleep_r && !i_ost_active && !clear_evt
        |=> o_wdt_reset && !o_wdt_wake ##1 !o_wdt_reset)
        else $error("awake timeout gave no reset pulse");
    a_timeout_wake: assert property (timeout && asleep_r && !i_ost_active && !clear_evt
        && !i_clear_watchdog_instr |=> o_wdt_wake && !to_r && !asleep_r)
        else $error("sleep timeout gave no wake");
    a_sleep_flags: assert property (i_sleep_enter && wdt_en && !asleep_r
        |=> asleep_r && to_r && !pd_r && pre_r == 16'h0000)
        else $error("sleep entry flags wrong");
    a_wake_clears: assert property (i_wake && asleep_r && !i_sleep_enter
        |=> pre_r == 16'h0000 && !asleep_r)
        else $error("wake did not clear watchdog");

    c_reset_out: cover property (o_wdt_reset);
    c_wake_out: cover property (o_wdt_wake);
    c_sleep_entry: cover property (i_sleep_enter && wdt_en ##1 asleep_r);
    c_ost_resume: cover property (i_ost_active ##1 !i_ost_active ##[1:100] lf_tick);

endmodule

// File: tb/wdt_core_bench.sv
// Self-checking bench for the watchdog timer block.
// Assumes the package and the core are compiled first. The bench plays the register master
// and the CPU core events itself, and makes a sped-up stand-in for the slow oscillator.
`timescale 1ns/1ps

module wdt_core_bench;

    // ==========================================================
    // Stimulus and observed signals
    logic i_sys_clk = 1'b0;           // 10 MHz system clock
    logic i_rst_b = 1'b0;             // Reset, active low
    wdt_pkg::bus_req_t bus = '0;      // Register request
    logic [7:0] o_rdata;              // Read data
    logic i_lfosc = 1'b0;             // Slow oscillator stand-in
    logic [7:0] fuse = 8'hA5;         // Fuse strap, watchdog fuse enable clear
    logic clr = 1'b0;                 // Clear instruction pulse
    logic osc_fail = 1'b0;            // Oscillator failure
    logic sleep = 1'b0;               // Sleep instruction pulse
    logic wake = 1'b0;                // Wake from another source
    logic osc_startup_counter = 1'b0;                 // Start-up count running
    logic o_wdt_reset;                // Time-out reset pulse
    logic o_wdt_wake;                 // Time-out wake pulse
    logic o_lfosc_request;            // Watchdog enabled
    logic o_timer_zero_prescaled;           // Prescaler given to timer zero
    logic [2:0] o_timer_zero_rate;          // Timer zero rate
    int fail_count = 0;               // Mismatches
    int num_checks = 0;               // Comparisons made
    integer seed = 32'h1AFBE08E;      // Fixed seed
    logic [7:0] exp_q[$];             // Expected read data, oldest first
    logic exp_p[$];                   // Expected pulse kind, 1 = wake
    logic rd_d = 1'b0;                // Read strobe one cycle late
    int lf_div = 0;                   // Oscillator stand-in divider
    logic [7:0] d;                    // Random data

    // ==========================================================
    // Clocks
    initial begin
        forever #50 i_sys_clk = ~i_sys_clk;
    end

    // Counts are in oscillator edges, so a 10-cycle period keeps the run short without changing any expectation
    always @(posedge i_sys_clk) begin
        if (lf_div == 4) begin
            lf_div <= 0;
            i_lfosc <= ~i_lfosc;
        end else begin
            lf_div <= lf_div + 1;
        end
    end

    wdt_core i_wdt_core (
        .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_bus(bus), .o_rdata(o_rdata),
        .i_lfosc(i_lfosc), .i_fuse_word(fuse), .i_clear_watchdog_instr(clr), .i_osc_fail(osc_fail),
        .i_sleep_enter(sleep), .i_wake(wake), .i_ost_active(osc_startup_counter), .o_wdt_reset(o_wdt_reset),
        .o_wdt_wake(o_wdt_wake), .o_lfosc_request(o_lfosc_request),
        .o_timer_zero_prescaled(o_timer_zero_prescaled), .o_timer_zero_rate(o_timer_zero_rate)
    );

    // ==========================================================
    // Compare and report helpers
    task check(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task results();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ==========================================================
    // Monitor: read data only stands in the cycle after the strobe, so look exactly there
    always @(posedge i_sys_clk) begin
        rd_d <= bus.rd;
    end

    always @(negedge i_sys_clk) begin
        if (rd_d) begin
            if (exp_q.size() == 0) check("unexpected read", 8'h00, 8'hFF);
            else check("read data", exp_q.pop_front(), o_rdata);
        end
        // Any pulse must match a noted expectation, so spurious pulses also count
        if (o_wdt_reset || o_wdt_wake) begin
            if (exp_p.size() == 0) check("unexpected pulse", 8'h00, 8'hFF);
            else check("pulse is wake", {7'h00, exp_p.pop_front()}, {7'h00, o_wdt_wake});
        end
    end

    // ==========================================================
    // Register master: one-cycle strobes; a gap cycle avoids two assignments in one step
    task wr(input logic [13:0] a, input logic [7:0] v);
        @(posedge i_sys_clk);
        bus <= {a, v, 2'b10};
        @(posedge i_sys_clk);
        bus <= '0;
    endtask

    task rd(input logic [13:0] a, input logic [7:0] e);
        @(posedge i_sys_clk);
        bus <= {a, 8'h00, 2'b01};
        exp_q.push_back(e);
        @(posedge i_sys_clk);
        bus <= '0;
    endtask

    // One time-out run; kind picks the event put in at cycle 200 (kind 5 adds a wake at cycle 300, kind 6 sets the fuse before the run starts):
    // 0 none, 1 clear, 2 osc fail, 3 start-up hold, 4 sleep, 5 sleep then wake, 6 fuse enable
    task run_case(input logic [7:0] opt, input logic [7:0] ctl, input int kind, input int ex,
                  input logic [7:0] st);
        int t;
        t = 0;
        wr(wdt_pkg::ADDR_CTRL, 8'h00);
        wr(wdt_pkg::ADDR_OPTION, opt);
        if (kind == 6) fuse[3] <= 1'b1;
        exp_p.push_back(kind == 4);
        wr(wdt_pkg::ADDR_CTRL, ctl);
        // Bounded wait; the window allows for oscillator phase and synchroniser delay
        while (t < ex + 25) begin
            @(posedge i_sys_clk);
            clr <= (kind == 1 && t == 200);
            osc_fail <= (kind == 2 && t == 200);
            osc_startup_counter <= (kind == 3 && t == 200);
            sleep <= (kind >= 4 && kind <= 5 && t == 200);
            wake <= (kind == 5 && t == 300);
            @(negedge i_sys_clk);
            if (t == 100) check("clock request", 8'h01, {7'h00, o_lfosc_request});
            if (o_wdt_reset || o_wdt_wake) break;
            t++;
        end
        check("time-out cycle in window", 8'h01, {7'h00, (t >= ex - 15) && (t < ex + 25)});
        // A run that used up its bound has already counted a mismatch; stop here
        if (t >= ex + 25) results();
        @(posedge i_sys_clk);
        fuse[3] <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        wr(wdt_pkg::ADDR_CTRL, 8'h00);
        rd(wdt_pkg::ADDR_FLAGS, st);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        rd(wdt_pkg::ADDR_CTRL, 8'h08);
        rd(wdt_pkg::ADDR_OPTION, 8'hFF);
        rd(wdt_pkg::ADDR_FLAGS, 8'h18);
        rd(wdt_pkg::ADDR_FUSE, 8'hA5);
        rd(14'h0055, 8'h00);
        @(negedge i_sys_clk);
        check("timer zero rate", 8'h07, {5'h00, o_timer_zero_rate});
        check("timer zero prescaled", 8'h00, {7'h00, o_timer_zero_prescaled});
        // Read-only fuse word and the two status bits that software cannot write
        wr(wdt_pkg::ADDR_FUSE, 8'h00);
        rd(wdt_pkg::ADDR_FUSE, 8'hA5);
        wr(wdt_pkg::ADDR_FLAGS, 8'hE7);
        rd(wdt_pkg::ADDR_FLAGS, 8'hFF);
        wr(wdt_pkg::ADDR_FLAGS, 8'h00);
        rd(wdt_pkg::ADDR_FLAGS, 8'h18);
        // Random control and option values; too short a span for any time-out to land
        repeat (4) begin
            d = $random(seed);
            wr(wdt_pkg::ADDR_CTRL, d);
            rd(wdt_pkg::ADDR_CTRL, d & 8'h1F);
            wr(wdt_pkg::ADDR_OPTION, d);
            @(negedge i_sys_clk);
            check("timer zero rate", {5'h00, d[2:0]}, {5'h00, o_timer_zero_rate});
            check("timer zero prescaled", {7'h00, ~d[3]}, {7'h00, o_timer_zero_prescaled});
        end
        run_case(8'h00, 8'h01, 0, 320, 8'h08);
        run_case(8'h00, 8'h03, 0, 640, 8'h08);
        run_case(8'h09, 8'h01, 0, 640, 8'h08);
        run_case(8'h0A, 8'h05, 0, 5120, 8'h08);
        run_case(8'h00, 8'h01, 1, 520, 8'h08);
        run_case(8'h00, 8'h01, 2, 520, 8'h08);
        run_case(8'h00, 8'h01, 3, 520, 8'h08);
        run_case(8'h00, 8'h01, 4, 520, 8'h00);
        run_case(8'h00, 8'h01, 5, 620, 8'h00);
        run_case(8'h00, 8'h00, 6, 320, 8'h00);
        // Second reset in mid-run: registers return to their reset values
        wr(wdt_pkg::ADDR_CTRL, 8'h1F);
        @(posedge i_sys_clk);
        i_rst_b <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        rd(wdt_pkg::ADDR_CTRL, 8'h08);
        rd(wdt_pkg::ADDR_OPTION, 8'hFF);
        rd(wdt_pkg::ADDR_FLAGS, 8'h18);
        repeat (3) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        check("clock request off", 8'h00, {7'h00, o_lfosc_request});
        check("notes left over", 8'h00, 8'(exp_q.size() + exp_p.size()));
        results();
    end

endmodule
